// ### verification/fpu_packed_state_registers_test.sv
`timescale 1ns/100ps

module fpu_packed_state_registers_test
  import fpu_state_pkg::*;
;
  logic        CLK = 0, SYS_RST = 1;
  logic        STACK_PUSH = 0, STACK_POP = 0, DREG_WE = 0, PACKED_WE = 0;
  logic        PACKED_OP = 0, MM_CLEAR = 0, EXC_VALID = 0, STATUS_CLEAR = 0;
  logic        CC_WE = 0, MODE_WE = 0, PTR_WE = 0, OPND_VALID = 0;
  logic        ENV_RD = 0, SAVE_RD = 0;
  logic [2:0]  DREG_IDX = 0, PACKED_IDX = 0, PACKED_SRC_A = 0;
  logic [2:0]  PACKED_SRC_B = 0, PACKED_DST = 0, SAVE_IDX = 0;
  ext_real_t   DREG_WDATA = 0, SAVE_DATA;
  packed_t     PACKED_WDATA = 0;
  packed_fmt_e PACKED_FMT = PK_BYTE;
  logic [6:0]  EXC_FLAGS = 0;
  logic [3:0]  CC_VALUE = 0;
  logic [15:0] MODE_WDATA = 0, STATUS_WORD_OUT, MODE_WORD_OUT;
  logic [31:0] INSTR_PTR = 0, OPND_PTR = 0;
  logic [1:0]  ROUND_SEL, PREC_SEL;
  logic        ERROR_SUMMARY, ENV_VALID, SAVE_VALID;
  env_s        ENV_OUT, env;
  int          errors = 0, compares = 0;
  ext_real_t   dv [6] = '{80'h3fff_8000_0000_0000_0000, 80'h0000,
                          80'h0001, 80'h7fff_8000_0000_0000_0000,
                          80'h7fff_c000_0000_0000_0000,
                          80'h4000_0000_0000_0000_0000};
  packed_t     opa = 64'h80ff_7fff_ffff_0001, opb = 64'h8001_0001_0001_ffff;

  fpu_packed_state_registers i_dut (
    .CLK, .SYS_RST, .STACK_PUSH, .STACK_POP, .DREG_WE, .DREG_IDX,
    .DREG_WDATA, .PACKED_WE, .PACKED_IDX, .PACKED_WDATA, .PACKED_OP,
    .PACKED_FMT, .PACKED_SRC_A, .PACKED_SRC_B, .PACKED_DST, .MM_CLEAR,
    .EXC_VALID, .EXC_FLAGS, .STATUS_CLEAR, .CC_WE, .CC_VALUE, .MODE_WE,
    .MODE_WDATA, .PTR_WE, .INSTR_PTR, .OPND_VALID, .OPND_PTR, .ENV_RD,
    .SAVE_RD, .SAVE_IDX, .STATUS_WORD_OUT, .MODE_WORD_OUT, .ROUND_SEL,
    .PREC_SEL, .ERROR_SUMMARY, .ENV_OUT, .ENV_VALID, .SAVE_DATA,
    .SAVE_VALID
  );

  initial begin
    forever #2 CLK = ~CLK;
  end

  // ----------------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------------
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check16(string what, logic [15:0] exp, logic [15:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check80(string what, ext_real_t exp, ext_real_t got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Lane-wise wrapping add, carries cut at every element boundary.
  function automatic packed_t lane_add(int w, packed_t a, packed_t b);
    packed_t r;
    logic    c;
    c = 0;
    for (int i = 0; i < 64; i++) begin
      if (i % w == 0) c = 0;
      r[i] = a[i] ^ b[i] ^ c;
      c = (a[i] & b[i]) | (c & (a[i] ^ b[i]));
    end
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------------
  // Ends the pulse at the edge that takes it and lets outputs settle.
  task automatic op_done;
    @(posedge CLK);
    {STACK_PUSH, STACK_POP, DREG_WE, PACKED_WE, PACKED_OP, MM_CLEAR,
     EXC_VALID, STATUS_CLEAR, CC_WE, MODE_WE, PTR_WE, ENV_RD,
     SAVE_RD} <= '0;
    #1;
  endtask

  task automatic write_mode(logic [15:0] v);
    @(posedge CLK);
    MODE_WE <= 1;
    MODE_WDATA <= v;
    op_done;
  endtask

  task automatic raise_exc(logic [6:0] f, logic clr);
    @(posedge CLK);
    EXC_VALID <= !clr;
    STATUS_CLEAR <= clr;
    EXC_FLAGS <= f;
    op_done;
  endtask

  task automatic stack_op(logic push, logic pop, logic clr);
    @(posedge CLK);
    STACK_PUSH <= push;
    STACK_POP <= pop;
    MM_CLEAR <= clr;
    op_done;
  endtask

  task automatic wait_valid(ref logic flag);
    int n;
    n = 0;
    while (flag !== 1'b1 && n < 8) begin
      @(posedge CLK);
      #1;
      n++;
    end
    if (flag !== 1'b1) begin
      errors++;
      $display("MISMATCH read_valid expected 1 seen %b", flag);
      give_verdict;
    end
  endtask

  task automatic read_env;
    @(posedge CLK);
    ENV_RD <= 1;
    op_done;
    wait_valid(ENV_VALID);
    env = ENV_OUT;
  endtask

  task automatic read_save(logic [2:0] idx, ext_real_t exp);
    @(posedge CLK);
    SAVE_RD <= 1;
    SAVE_IDX <= idx;
    op_done;
    wait_valid(SAVE_VALID);
    check80("save_data", exp, SAVE_DATA);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge CLK);
    SYS_RST <= 0;
    #1;
    check16("status_reset", 16'h0000, STATUS_WORD_OUT);
    check16("mode_reset", 16'h033f, MODE_WORD_OUT);
    read_env;
    check16("tag_reset", 16'hffff, env.tag_word);
    for (int rc = 0; rc < 4; rc++) begin
      for (int pc = 0; pc < 4; pc++) begin
        write_mode({4'h0, rc[1:0], pc[1:0], 8'h15});
        check16("mode", {4'h0, rc[1:0], pc[1:0], 8'h15}, MODE_WORD_OUT);
        check16("round", {14'h0, rc[1:0]}, {14'h0, ROUND_SEL});
        check16("prec", {14'h0, pc[1:0]}, {14'h0, PREC_SEL});
      end
    end
    write_mode(16'hffff);
    check16("mode_mask", 16'h0f3f, MODE_WORD_OUT);
    for (int k = 0; k < 6; k++) begin
      raise_exc(7'h00, 1);
      write_mode(16'h033f & ~(16'h0001 << k));
      raise_exc(7'h01 << k, 0);
      check16("status_exc", 16'h8080 | (16'h0001 << k),
              STATUS_WORD_OUT);
      check16("err_sum", 16'h0001, {15'h0, ERROR_SUMMARY});
    end
    write_mode(16'h033f);
    raise_exc(7'h00, 1);
    raise_exc(7'h7f, 0);
    check16("status_masked", 16'h007f, STATUS_WORD_OUT);
    check16("err_masked", 16'h0000, {15'h0, ERROR_SUMMARY});
    write_mode(16'h033e);
    check16("status_unmask", 16'h80ff, STATUS_WORD_OUT);
    raise_exc(7'h00, 1);
    check16("status_clear", 16'h0000, STATUS_WORD_OUT);
    write_mode(16'h033f);
    @(posedge CLK);
    CC_WE <= 1;
    CC_VALUE <= 4'ha;
    op_done;
    check16("cond_codes", 16'h4200, STATUS_WORD_OUT);
    @(posedge CLK);
    CC_WE <= 1;
    CC_VALUE <= 4'h5;
    op_done;
    check16("cond_codes", 16'h0500, STATUS_WORD_OUT);
    stack_op(1, 0, 0);
    check16("top_push", 16'h3d00, STATUS_WORD_OUT);
    stack_op(1, 0, 0);
    stack_op(0, 1, 0);
    check16("top_pop", 16'h3d00, STATUS_WORD_OUT);
    stack_op(0, 0, 1);
    check16("top_clear", 16'h0500, STATUS_WORD_OUT);
    for (int i = 0; i < 6; i++) begin
      @(posedge CLK);
      DREG_WE <= 1;
      DREG_IDX <= i[2:0];
      DREG_WDATA <= dv[i];
      op_done;
    end
    @(posedge CLK);
    PTR_WE <= 1;
    OPND_VALID <= 1;
    INSTR_PTR <= 32'h1234_5678;
    OPND_PTR <= 32'h9abc_def0;
    op_done;
    @(posedge CLK);
    PTR_WE <= 1;
    OPND_VALID <= 0;
    INSTR_PTR <= 32'h0000_1000;
    op_done;
    read_env;
    check16("tag_class", 16'hfaa4, env.tag_word);
    check16("env_status", 16'h0500, env.status_word);
    check16("env_mode", 16'h033f, env.mode_word);
    check80("env_iptr", 80'h1000, {48'h0, env.instr_ptr});
    check80("env_optr", 80'h9abc_def0, {48'h0, env.opnd_ptr});
    read_save(3'h2, dv[2]);
    stack_op(0, 1, 0);
    read_env;
    check16("tag_pop", 16'hfaa7, env.tag_word);
    stack_op(0, 0, 1);
    read_env;
    check16("tag_clear", 16'hffff, env.tag_word);
    stack_op(1, 0, 0);
    @(posedge CLK);
    PACKED_WE <= 1;
    PACKED_IDX <= 3'h3;
    PACKED_WDATA <= opa;
    op_done;
    check16("top_packed", 16'h0500, STATUS_WORD_OUT);
    read_save(3'h3, {16'hffff, opa});
    for (int f = 0; f < 4; f++) begin
      @(posedge CLK);
      PACKED_WE <= 1;
      PACKED_IDX <= 3'h5;
      PACKED_WDATA <= opb;
      op_done;
      @(posedge CLK);
      PACKED_OP <= 1;
      PACKED_FMT <= packed_fmt_e'(f[1:0]);
      PACKED_SRC_A <= 3'h3;
      PACKED_SRC_B <= 3'h5;
      PACKED_DST <= 3'h5;
      op_done;
      read_save(3'h5,
                {16'hffff, lane_add(8 << f, opa, opb)});
    end
    read_env;
    check16("tag_packed", 16'h0000, env.tag_word);
    give_verdict;
  end
endmodule

// ### verilog/fpu_packed_state_registers.sv
`timescale 1ns/100ps
`include "fpu_state_map.svh"

// Overview of operation
// - A two-bit tag field is kept for each of the eight physical registers.
// - Tags encode valid 00, zero 01, special 10 and empty 11.
// - Denormal, infinity, NaN and unsupported values are tagged special.
// - Tags update in hardware and are seen only via the stored environment.
// - Status bits 13:11 hold the stack top, bits 14 and 10:8 the codes.
// - Status bit 7 is set when an exception with a clear mask is seen.
// - Status bit 15 always reads as a copy of bit 7.
// - Status bits 6 down to 0 hold the seven exception flags.
// - Mode bits 11:10 select the rounding mode.
// - Mode bits 9:8 select a 24, 53 or 64 bit mantissa; 01 is reserved.
// - Mode bits 5:0 mask the six exceptions in status flag order.
// - Instruction and operand address pointers are kept.
// - Eight 64-bit packed registers alias the data register storage.
// - Packed operands are bytes, words, doublewords or one quadword.
// - Packed operations act on every element separately in parallel.
// - The state clear sets the stack top to zero and all tags empty except one loaded by DREG_WE in that cycle.
module fpu_packed_state_registers
  import fpu_state_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  input  wire logic              CLK,
  input  wire logic              SYS_RST,
  input  wire logic              STACK_PUSH,
  input  wire logic              STACK_POP,
  input  wire logic              DREG_WE,
  input  wire logic [2:0]        DREG_IDX,
  input  wire ext_real_t         DREG_WDATA,
  input  wire logic              PACKED_WE,
  input  wire logic [2:0]        PACKED_IDX,
  input  wire packed_t           PACKED_WDATA,
  input  wire logic              PACKED_OP,
  input  wire packed_fmt_e       PACKED_FMT,
  input  wire logic [2:0]        PACKED_SRC_A,
  input  wire logic [2:0]        PACKED_SRC_B,
  input  wire logic [2:0]        PACKED_DST,
  input  wire logic              MM_CLEAR,
  input  wire logic              EXC_VALID,
  input  wire logic [6:0]        EXC_FLAGS,
  input  wire logic              STATUS_CLEAR,
  input  wire logic              CC_WE,
  input  wire logic [3:0]        CC_VALUE,
  input  wire logic              MODE_WE,
  input  wire logic [15:0]       MODE_WDATA,
  input  wire logic              PTR_WE,
  input  wire logic [ADDR_W-1:0] INSTR_PTR,
  input  wire logic              OPND_VALID,
  input  wire logic [ADDR_W-1:0] OPND_PTR,
  input  wire logic              ENV_RD,
  input  wire logic              SAVE_RD,
  input  wire logic [2:0]        SAVE_IDX,
  output logic      [15:0]       STATUS_WORD_OUT,
  output logic      [15:0]       MODE_WORD_OUT,
  output logic      [1:0]        ROUND_SEL,
  output logic      [1:0]        PREC_SEL,
  output logic                   ERROR_SUMMARY,
  output env_s                   ENV_OUT,
  output logic                   ENV_VALID,
  output ext_real_t              SAVE_DATA,
  output logic                   SAVE_VALID
);

  // ----------------------------------------------------------------------
  // Tag classification of an extended real value.
  // ----------------------------------------------------------------------
  function automatic tag_class_e classify(input ext_real_t v);
    logic [14:0] exp;
    logic        int_bit;
    logic [62:0] frac;
    exp     = v[78:64];
    int_bit = v[63];
    frac    = v[62:0];
    if (exp == 15'h0000 && !int_bit && frac == 63'h0)
      classify = TAG_ZERO;
    else if (exp == 15'h0000 || exp == `FPU_EXP_ALL_ONES || !int_bit)
      classify = TAG_SPECIAL;
    else
      classify = TAG_VALID;
  endfunction

  // ----------------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------------
  ext_real_t [7:0]    dreg_q;
  logic [7:0][1:0]    tag_q;
  logic [7:0][1:0]    tag_d;
  logic [2:0]         top_q;
  logic [2:0]         top_d;
  logic [6:0]         flags_q;
  logic [6:0]         flags_d;
  logic [3:0]         cc_q;
  logic [3:0]         cc_d;
  logic [15:0]        mode_q;
  logic [15:0]        mode_d;
  logic [ADDR_W-1:0]  iptr_q;
  logic [ADDR_W-1:0]  optr_q;
  logic               err_sum_d;
  logic [15:0]        status_d;
  packed_t            packed_sum;

  // ----------------------------------------------------------------------
  // Packed arithmetic on aliased register storage.
  // ----------------------------------------------------------------------
  wire packed_t src_a = dreg_q[PACKED_SRC_A][63:0];
  wire packed_t src_b = dreg_q[PACKED_SRC_B][63:0];
  wire          packed_any = PACKED_WE || PACKED_OP;

  packed_adder #(
    .LANES (8)
  ) u_adder (
    .fmt   (PACKED_FMT),
    .a     (src_a),
    .b     (src_b),
    .sum   (packed_sum)
  );

  always_ff @(posedge CLK) begin
    if (DREG_WE) begin
      dreg_q[DREG_IDX] <= DREG_WDATA;
    end
    if (PACKED_WE) begin
      dreg_q[PACKED_IDX] <= {`FPU_PACKED_EXP_FILL, PACKED_WDATA};
    end
    if (PACKED_OP) begin
      dreg_q[PACKED_DST] <= {`FPU_PACKED_EXP_FILL, packed_sum};
    end
  end

  // ----------------------------------------------------------------------
  // Stack top and tag word.
  // ----------------------------------------------------------------------
  always_comb begin
    if (MM_CLEAR || packed_any)
      top_d = `FPU_TOP_RESET;
    else if (STACK_PUSH && !STACK_POP)
      top_d = 3'(top_q - 3'h1);
    else if (STACK_POP && !STACK_PUSH)
      top_d = 3'(top_q + 3'h1);
    else
      top_d = top_q;
  end

  always_comb begin
    tag_d = tag_q;
    if (MM_CLEAR)
      tag_d = `FPU_TAG_ALL_EMPTY;
    else if (packed_any)
      tag_d = `FPU_TAG_ALL_VALID;
    if (STACK_POP && !STACK_PUSH && !MM_CLEAR && !packed_any)
      tag_d[top_q] = TAG_EMPTY;
    if (DREG_WE)
      tag_d[DREG_IDX] = classify(DREG_WDATA);
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      tag_q <= `FPU_TAG_ALL_EMPTY;
      top_q <= `FPU_TOP_RESET;
    end else begin
      tag_q <= tag_d;
      top_q <= top_d;
    end
  end

  // ----------------------------------------------------------------------
  // Exception flags, error summary and mode control.
  // ----------------------------------------------------------------------
  always_comb begin
    flags_d = STATUS_CLEAR ? 7'h00 : flags_q;
    if (EXC_VALID)
      flags_d = flags_d | EXC_FLAGS;
    cc_d   = CC_WE ? CC_VALUE : cc_q;
    mode_d = MODE_WE ? (MODE_WDATA & `FPU_MC_WR_MASK) : mode_q;
  end

  assign err_sum_d = |(flags_d[`FPU_SW_FLAG_MSB:0] &
                       ~mode_d[`FPU_MC_MASK_MSB:0]);

  always_comb begin
    status_d = `FPU_SW_RESET;
    status_d[`FPU_SW_BUSY_COPY] = err_sum_d;
    status_d[`FPU_SW_CC3]       = cc_d[3];
    status_d[`FPU_SW_TOP_MSB:`FPU_SW_TOP_LSB] = top_d;
    status_d[`FPU_SW_CC2]       = cc_d[2];
    status_d[`FPU_SW_CC1]       = cc_d[1];
    status_d[`FPU_SW_CC0]       = cc_d[0];
    status_d[`FPU_SW_ERR_SUM]   = err_sum_d;
    status_d[`FPU_SW_STK_FAULT:0] = flags_d;
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      flags_q <= 7'h00;
      cc_q    <= 4'h0;
      mode_q  <= `FPU_MC_RESET;
    end else begin
      flags_q <= flags_d;
      cc_q    <= cc_d;
      mode_q  <= mode_d;
    end
  end

  // ----------------------------------------------------------------------
  // Instruction and operand pointers.
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      iptr_q <= '0;
      optr_q <= '0;
    end else if (PTR_WE) begin
      iptr_q <= INSTR_PTR;
      if (OPND_VALID)
        optr_q <= OPND_PTR;
    end
  end

  // ----------------------------------------------------------------------
  // Registered outputs.
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      STATUS_WORD_OUT <= `FPU_SW_RESET;
      MODE_WORD_OUT   <= `FPU_MC_RESET;
      ROUND_SEL       <= 2'h0;
      PREC_SEL        <= 2'h0;
      ERROR_SUMMARY   <= 1'b0;
    end else begin
      STATUS_WORD_OUT <= status_d;
      MODE_WORD_OUT   <= mode_d;
      ROUND_SEL <= mode_d[`FPU_MC_ROUND_MSB:`FPU_MC_ROUND_LSB];
      PREC_SEL  <= mode_d[`FPU_MC_PREC_MSB:`FPU_MC_PREC_LSB];
      ERROR_SUMMARY   <= err_sum_d;
    end
  end

  // Tags leave the block only as part of a stored environment.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      ENV_OUT    <= '0;
      ENV_VALID  <= 1'b0;
      SAVE_DATA  <= '0;
      SAVE_VALID <= 1'b0;
    end else begin
      ENV_VALID  <= ENV_RD;
      SAVE_VALID <= SAVE_RD;
      if (ENV_RD) begin
        ENV_OUT.tag_word    <= tag_q;
        ENV_OUT.status_word <= STATUS_WORD_OUT;
        ENV_OUT.mode_word   <= mode_q;
        ENV_OUT.instr_ptr   <= 32'(iptr_q);
        ENV_OUT.opnd_ptr    <= 32'(optr_q);
      end
      if (SAVE_RD)
        SAVE_DATA <= dreg_q[SAVE_IDX];
    end
  end

  // ----------------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  sequence clear_req;
    MM_CLEAR && !DREG_WE && !packed_any;
  endsequence

  sequence state_cleared;
    tag_q == `FPU_TAG_ALL_EMPTY ##0
    STATUS_WORD_OUT[`FPU_SW_TOP_MSB:`FPU_SW_TOP_LSB] == 3'h0;
  endsequence

  state_clear_a: assert property (clear_req |=> state_cleared)
    else $error("state clear did not empty tags and zero the top");

  busy_copy_a: assert property (
    STATUS_WORD_OUT[`FPU_SW_BUSY_COPY] ==
    STATUS_WORD_OUT[`FPU_SW_ERR_SUM])
    else $error("status bit 15 differs from the error summary");

  summary_cause_a: assert property (
    ##1 ERROR_SUMMARY == |(STATUS_WORD_OUT[`FPU_SW_FLAG_MSB:0] &
                           ~MODE_WORD_OUT[`FPU_MC_MASK_MSB:0]))
    else $error("error summary does not match unmasked flags");

  flag_sticky_a: assert property (
    EXC_VALID && !STATUS_CLEAR |=>
    (STATUS_WORD_OUT[6:0] & $past(EXC_FLAGS)) == $past(EXC_FLAGS))
    else $error("raised exception flag not held in status");

  zero_tag_a: assert property (
    DREG_WE && DREG_WDATA == 80'h0 |=>
    tag_q[$past(DREG_IDX)] == TAG_ZERO)
    else $error("zero value not tagged zero");

  special_tag_a: assert property (
    DREG_WE && DREG_WDATA[78:64] == `FPU_EXP_ALL_ONES |=>
    tag_q[$past(DREG_IDX)] == TAG_SPECIAL)
    else $error("infinity or NaN not tagged special");

  round_select_a: assert property (
    MODE_WE |=> ROUND_SEL == $past(MODE_WDATA[11:10]) &&
                PREC_SEL == $past(MODE_WDATA[9:8]))
    else $error("rounding or precision select not loaded");

  stack_push_a: assert property (
    STACK_PUSH && !STACK_POP && !MM_CLEAR && !packed_any |=>
    top_q == 3'($past(top_q) - 3'h1))
    else $error("push did not step the stack top down");

  byte_lane_a: assert property (
    PACKED_OP && PACKED_FMT == PK_BYTE |=>
    dreg_q[$past(PACKED_DST)][15:8] ==
      8'($past(src_a[15:8]) + $past(src_b[15:8])))
    else $error("byte lane add leaked a carry");

  env_tags_a: assert property (
    ENV_RD |=> ENV_VALID && ENV_OUT.tag_word == $past(tag_q))
    else $error("stored environment lost the tag word");

endmodule

// ### verilog/fpu_state_map.svh
`ifndef FPU_STATE_MAP_SVH
`define FPU_STATE_MAP_SVH

// ----------------------------------------------------------------------
// Status word fields
// ----------------------------------------------------------------------
`define FPU_SW_BUSY_COPY    15
`define FPU_SW_CC3          14
`define FPU_SW_TOP_MSB      13
`define FPU_SW_TOP_LSB      11
`define FPU_SW_CC2          10
`define FPU_SW_CC1          9
`define FPU_SW_CC0          8
`define FPU_SW_ERR_SUM      7
`define FPU_SW_STK_FAULT    6
`define FPU_SW_FLAG_MSB     5
`define FPU_SW_RESET        16'h0000

// ----------------------------------------------------------------------
// Mode control word fields
// ----------------------------------------------------------------------
`define FPU_MC_ROUND_MSB    11
`define FPU_MC_ROUND_LSB    10
`define FPU_MC_PREC_MSB     9
`define FPU_MC_PREC_LSB     8
`define FPU_MC_MASK_MSB     5
`define FPU_MC_WR_MASK      16'h0F3F
`define FPU_MC_RESET        16'h033F

// ----------------------------------------------------------------------
// Tag word and data register constants
// ----------------------------------------------------------------------
`define FPU_TAG_ALL_EMPTY   16'hFFFF
`define FPU_TAG_ALL_VALID   16'h0000
`define FPU_EXP_ALL_ONES    15'h7FFF
`define FPU_PACKED_EXP_FILL 16'hFFFF
`define FPU_TOP_RESET       3'h0

`endif

// ### verilog/fpu_state_pkg.sv
package fpu_state_pkg;

  typedef enum logic [1:0] {
    TAG_VALID   = 2'h0,
    TAG_ZERO    = 2'h1,
    TAG_SPECIAL = 2'h2,
    TAG_EMPTY   = 2'h3
  } tag_class_e;

  typedef enum logic [1:0] {
    PK_BYTE  = 2'h0,
    PK_WORD  = 2'h1,
    PK_DWORD = 2'h2,
    PK_QWORD = 2'h3
  } packed_fmt_e;

  typedef logic [79:0] ext_real_t;
  typedef logic [63:0] packed_t;

  typedef struct packed {
    logic [15:0] tag_word;
    logic [15:0] status_word;
    logic [15:0] mode_word;
    logic [31:0] instr_ptr;
    logic [31:0] opnd_ptr;
  } env_s;

endpackage

// ### verilog/packed_adder.sv
`timescale 1ns/100ps

module packed_adder
  import fpu_state_pkg::*;
#(
  parameter int LANES = 8
) (
  input  wire packed_fmt_e         fmt,
  input  wire logic [LANES*8-1:0]  a,
  input  wire logic [LANES*8-1:0]  b,
  output logic      [LANES*8-1:0]  sum
);

  // ----------------------------------------------------------------------
  // Byte slices with carries cut at every element boundary.
  // ----------------------------------------------------------------------
  logic [LANES-1:0] carry_out;
  logic [LANES-1:0] carry_in;

  genvar k;
  generate
    for (k = 0; k < LANES; k++) begin : g_lane
      localparam logic [2:0] KB = 3'(k);
      wire cut = (k == 0) ||
                 (fmt == PK_BYTE) ||
                 (fmt == PK_WORD  && KB[0]   == 1'b0) ||
                 (fmt == PK_DWORD && KB[1:0] == 2'h0);
      wire [8:0] part;
      if (k == 0) begin : g_first
        assign carry_in[k] = 1'b0;
      end else begin : g_rest
        assign carry_in[k] = cut ? 1'b0 : carry_out[k-1];
      end
      assign part = {1'b0, a[k*8 +: 8]} + {1'b0, b[k*8 +: 8]} +
                    {8'h00, carry_in[k]};
      assign sum[k*8 +: 8] = part[7:0];
      assign carry_out[k]  = part[8];
    end
  endgenerate

endmodule
